// ---- hw/pab_pkg.sv ----
/*
  Package for the serial PCM audio bus master: register map, field
  positions, reset values, bus rates and frame shapes.
  Assumes a 10 MHz system clock and an Avalon-MM register slave.
*/
// Operation
// - Device is bus master and drives both bit clock and frame sync.
// - Four lines: bit clock out, frame sync out, data out, data in.
// - Samples on both data lines are linear two's complement, never companded.
// - Voiceband mode runs a 520 kHz bit clock and 8 kHz frame sync.
// - Voiceband word is 16 bits: 13 sample bits then 3 zero bits.
// - Voiceband data in both directions starts after frame sync falls.
// - Voiceband sync is high one bit period, then 16 data bit periods.
// - After 16 bits both data lines idle until the next 125 us sync.
// - Data line drivers should go high impedance in the idle part.
// - Stereo modes use 705 kHz to 1.4 MHz clock, 22.05-44.1 kHz sync.
// - In stereo modes the frame sync lasts one whole 16-bit word.
// - Stereo modes send 16-bit samples out and ignore data in.
// - Ring tone values 6 to 9 pick mono voiceband timing; 7 is default.
// - Values 12-38 and 40-46 pick stereo low: 705 kHz, about 22 kHz.
// - Values 48 and 49 pick stereo mid: 1024 kHz clock, 32 kHz sync.
// - Values 10, 11, 39, 47 pick stereo high: 1.4 MHz, 44.1 kHz.
// - While the analog path is used all bus lines are tri-stated.
// - Digital path runs only after the path switch is written with 1.
// - Gain settings have no effect on the serial audio data.
// - Power-up is basic mode; advanced mode only by explicit configuration.
package pab_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_RTSEL = 5'h04;
  localparam logic [4:0] OFS_TXDATA = 5'h08;
  localparam logic [4:0] OFS_RXDATA = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_GAIN = 5'h14;
  // Field positions and reset values
  localparam int CTRL_DIG_BIT = 0;
  localparam int CTRL_ADV_BIT = 1;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_ACT_BIT = 2;
  localparam int STAT_FCNT_LSB = 8;
  localparam logic [5:0] RTSEL_RESET = 6'h07;
  localparam logic [15:0] GAIN_RESET = 16'h0343;
  // ----------------------------------------------------------------
  // Rates and frame shapes
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned VB_BCLK_HZ = 520000;
  localparam int unsigned VB_FS_HZ = 8000;
  localparam int unsigned STL_BCLK_HZ = 705000;
  localparam int unsigned STM_BCLK_HZ = 1024000;
  localparam int unsigned STH_BCLK_HZ = 1400000;
  localparam int unsigned VB_FRAME_BITS = VB_BCLK_HZ / VB_FS_HZ;
  localparam int unsigned ST_FRAME_BITS = 32;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned VB_SAMPLE_BITS = 13;
  localparam int unsigned VB_PAD_BITS = WORD_BITS - VB_SAMPLE_BITS;
  localparam logic [6:0] BIT_IDLE = 7'h7F;
  // Audio modes, picked from the ring tone selection
  typedef enum logic [1:0] {MODE_VOICE, MODE_ST_LOW, MODE_ST_MID, MODE_ST_HIGH} pab_mode_t;
endpackage

// ---- hw/pab_master.sv ----
/*
  PCM audio bus master: Avalon-MM register slave, bit clock generator,
  frame sync and serial shifters for voiceband and stereo ring tones.
  Assumes one 10 MHz clock; the data-in pin is asynchronous and is
  synchronised here. Pins are split into value and output enable.
*/
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module pab_master
  import pab_pkg::*;
(
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic BCLK_OUT,
  output logic BCLK_OE,
  output logic FRAME_SYNC_OUT,
  output logic FRAME_SYNC_OE,
  output logic DOUT,
  output logic DOUT_OE,
  input wire logic DIN
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic dig;
    logic adv;
    logic [5:0] rtsel;
    logic [31:0] txdata;
    logic [15:0] gain;
    logic [12:0] rxdata;
    logic [7:0] fcnt;
    pab_mode_t mode;
    logic [24:0] acc;
    logic bclk;
    logic [6:0] bitcnt;
    logic [31:0] txsh;
    logic [15:0] rxsh;
    logic fs;
    logic dout;
    logic dout_oe;
    logic pins_oe;
    logic din1;
    logic din2;
    logic din3;
    logic din_lvl;
  } pab_state_t;

  pab_state_t s;
  pab_state_t next_s;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Ring tone value to bus mode; unlisted values fall back to voiceband
  function automatic pab_mode_t decode_mode(input logic [5:0] rt);
    int v;
    v = int'(rt);
    if ((v >= 12 && v <= 38) || (v >= 40 && v <= 46)) begin
      decode_mode = MODE_ST_LOW;
    end else if (v == 48 || v == 49) begin
      decode_mode = MODE_ST_MID;
    end else if (v == 10 || v == 11 || v == 39 || v == 47) begin
      decode_mode = MODE_ST_HIGH;
    end else begin
      decode_mode = MODE_VOICE;
    end
  endfunction

  // Phase step per clock: two toggles per bit clock period
  function automatic logic [24:0] bclk_step(input pab_mode_t m);
    unique case (m)
      MODE_VOICE: bclk_step = 25'(2 * VB_BCLK_HZ);
      MODE_ST_LOW: bclk_step = 25'(2 * STL_BCLK_HZ);
      MODE_ST_MID: bclk_step = 25'(2 * STM_BCLK_HZ);
      MODE_ST_HIGH: bclk_step = 25'(2 * STH_BCLK_HZ);
    endcase
  endfunction

  // Byte lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge[8*i +: 8] = wd[8*i +: 8];
      end
    end
  endfunction

  // Word placed in the transmit shifter at frame start
  function automatic logic [31:0] frame_word(input pab_mode_t m, input logic [31:0] tx);
    if (m == MODE_VOICE) begin
      frame_word = {tx[VB_SAMPLE_BITS-1:0], {VB_PAD_BITS{1'b0}}, 16'h0000};
    end else begin
      frame_word = {tx[15:0], tx[31:16]};
    end
  endfunction

  logic [31:0] stat_word;
  logic [31:0] rd_word;
  logic tog;
  logic rise;
  logic fall;
  logic [6:0] last_bit;
  logic [6:0] nb;
  logic [24:0] acc_sum;
  logic [31:0] word;
  logic [15:0] rx_next;
  logic [31:0] gain_word;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    stat_word = 32'h0000_0000;
    stat_word[STAT_MODE_LSB +: 2] = s.mode;
    stat_word[STAT_ACT_BIT] = s.dig;
    stat_word[STAT_FCNT_LSB +: 8] = s.fcnt;
    // Gain merged as a full word so byte lanes line up, then trimmed
    gain_word = merge({16'h0, s.gain}, AVS_WRITEDATA, AVS_BYTEENABLE);
    rd_word = 32'h0000_0000;
    unique case (AVS_ADDRESS)
      OFS_CTRL: rd_word = {30'h0, s.adv, s.dig};
      OFS_RTSEL: rd_word = {26'h0, s.rtsel};
      OFS_TXDATA: rd_word = s.txdata;
      OFS_RXDATA: rd_word = {{19{s.rxdata[12]}}, s.rxdata};
      OFS_STATUS: rd_word = stat_word;
      OFS_GAIN: rd_word = {16'h0, s.gain};
      default: rd_word = 32'h0000_0000;
    endcase

    // One wait cycle, then the answer for one cycle; unmapped reads give 0
    next_s.waitreq = 1'b1;
    if ((AVS_READ || AVS_WRITE) && s.waitreq) begin
      next_s.waitreq = 1'b0;
      next_s.rdata = rd_word;
    end
    // Writes land at the edge where waitrequest is seen low
    if (AVS_WRITE && !s.waitreq) begin
      unique case (AVS_ADDRESS)
        OFS_CTRL: begin
          if (AVS_BYTEENABLE[0]) begin
            next_s.dig = AVS_WRITEDATA[CTRL_DIG_BIT];
            next_s.adv = AVS_WRITEDATA[CTRL_ADV_BIT];
          end
        end
        OFS_RTSEL: begin
          if (AVS_BYTEENABLE[0]) begin
            next_s.rtsel = AVS_WRITEDATA[5:0];
          end
        end
        OFS_TXDATA: next_s.txdata = merge(s.txdata, AVS_WRITEDATA, AVS_BYTEENABLE);
        OFS_GAIN: next_s.gain = gain_word[15:0];
        default: next_s.gain = s.gain;
      endcase
    end

    // Data-in pin: three flops, level taken when the last two agree
    next_s.din1 = DIN;
    next_s.din2 = s.din1;
    next_s.din3 = s.din2;
    if (s.din2 == s.din3) begin
      next_s.din_lvl = s.din3;
    end

    // Fractional divider: average rate exact, edges jitter by one clock
    acc_sum = s.acc + bclk_step(s.mode);
    tog = (acc_sum >= 25'(CLK_HZ));
    rise = tog && !s.bclk;
    fall = tog && s.bclk;
    last_bit = (s.mode == MODE_VOICE) ? 7'(VB_FRAME_BITS - 1) : 7'(ST_FRAME_BITS - 1);
    nb = (s.bitcnt >= last_bit) ? 7'h00 : 7'(s.bitcnt + 7'h01);
    word = 32'h0000_0000;
    rx_next = {s.rxsh[14:0], s.din_lvl};

    if (!s.dig) begin
      next_s.acc = 25'h0;
      next_s.bclk = 1'b0;
      next_s.bitcnt = BIT_IDLE;
      next_s.fs = 1'b0;
      next_s.dout = 1'b0;
      next_s.dout_oe = 1'b0;
      next_s.pins_oe = 1'b0;
      next_s.mode = decode_mode(s.rtsel);
    end else begin
      next_s.pins_oe = 1'b1;
      next_s.acc = tog ? 25'(acc_sum - 25'(CLK_HZ)) : acc_sum;
      next_s.bclk = s.bclk ^ tog;
      if (rise) begin
        next_s.bitcnt = nb;
        if (nb == 7'h00) begin
          next_s.mode = decode_mode(s.rtsel);
          next_s.fcnt = s.fcnt + 8'h01;
          word = frame_word(next_s.mode, s.txdata);
        end
        if (next_s.mode == MODE_VOICE) begin
          next_s.fs = (nb == 7'h00);
          next_s.dout_oe = (nb >= 7'h01) && (nb <= 7'(WORD_BITS));
          if (nb == 7'h00) begin
            next_s.txsh = word;
            next_s.dout = 1'b0;
          end else begin
            next_s.dout = s.txsh[31];
            next_s.txsh = {s.txsh[30:0], 1'b0};
          end
        end else begin
          next_s.fs = (nb < 7'(WORD_BITS));
          next_s.dout_oe = 1'b1;
          if (nb == 7'h00) begin
            next_s.dout = word[31];
            next_s.txsh = {word[30:0], 1'b0};
          end else begin
            next_s.dout = s.txsh[31];
            next_s.txsh = {s.txsh[30:0], 1'b0};
          end
        end
      end
      if (fall && s.mode == MODE_VOICE && s.bitcnt >= 7'h01 && s.bitcnt <= 7'(WORD_BITS)) begin
        next_s.rxsh = rx_next;
        if (s.bitcnt == 7'(WORD_BITS)) begin
          next_s.rxdata = rx_next[WORD_BITS-1:VB_PAD_BITS];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      s <= '{waitreq: 1'b1, rdata: 32'h0, dig: 1'b0, adv: 1'b0, rtsel: RTSEL_RESET,
             txdata: 32'h0, gain: GAIN_RESET, rxdata: 13'h0, fcnt: 8'h00, mode: MODE_VOICE,
             acc: 25'h0, bclk: 1'b0, bitcnt: BIT_IDLE, txsh: 32'h0, rxsh: 16'h0, fs: 1'b0,
             dout: 1'b0, dout_oe: 1'b0, pins_oe: 1'b0, din1: 1'b0, din2: 1'b0, din3: 1'b0,
             din_lvl: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign AVS_READDATA = s.rdata;
  assign AVS_WAITREQUEST = s.waitreq;
  assign BCLK_OUT = s.bclk;
  assign BCLK_OE = s.pins_oe;
  assign FRAME_SYNC_OUT = s.fs;
  assign FRAME_SYNC_OE = s.pins_oe;
  assign DOUT = s.dout;
  assign DOUT_OE = s.dout_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);

  sequence s_req_pending;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_one_answer;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence
  property p_bus_answer;
    s_req_pending |=> s_one_answer;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");

  property p_master_pins;
    s.dig ##1 s.dig |-> BCLK_OE && FRAME_SYNC_OE;
  endproperty
  a_master_pins: assert property (p_master_pins) else $error("clock or sync not driven");

  property p_analog_tristate;
    !s.dig |=> !BCLK_OE && !FRAME_SYNC_OE && !DOUT_OE;
  endproperty
  a_analog_tristate: assert property (p_analog_tristate) else $error("bus driven on analog path");

  property p_vb_sync_width;
    s.mode == MODE_VOICE && FRAME_SYNC_OUT |-> s.bitcnt == 7'h00 && !DOUT_OE;
  endproperty
  a_vb_sync_width: assert property (p_vb_sync_width) else $error("voice sync wider than a bit");

  property p_vb_idle;
    s.mode == MODE_VOICE && s.bitcnt > 7'(WORD_BITS) |-> !DOUT_OE;
  endproperty
  a_vb_idle: assert property (p_vb_idle) else $error("data driven in idle part");

  property p_vb_pad;
    s.mode == MODE_VOICE && DOUT_OE && s.bitcnt > 7'(VB_SAMPLE_BITS) |-> !DOUT;
  endproperty
  a_vb_pad: assert property (p_vb_pad) else $error("padding bit not zero");

  property p_vb_frame;
    s.mode == MODE_VOICE && s.bitcnt == 7'(VB_FRAME_BITS - 1) && next_s.bclk && !s.bclk
      |=> s.bitcnt == 7'h00 && FRAME_SYNC_OUT;
  endproperty
  a_vb_frame: assert property (p_vb_frame) else $error("voice frame not 65 bits");

  property p_st_sync;
    s.dig && s.mode != MODE_VOICE && s.bitcnt != BIT_IDLE |-> FRAME_SYNC_OUT == (s.bitcnt < 7'(WORD_BITS));
  endproperty
  a_st_sync: assert property (p_st_sync) else $error("stereo sync not one word");

  property p_st_no_rx;
    s.mode != MODE_VOICE && next_s.mode != MODE_VOICE |=> $stable(s.rxdata);
  endproperty
  a_st_no_rx: assert property (p_st_no_rx) else $error("data in used in stereo mode");

  property p_mono_sel;
    s.dig && s.bitcnt == 7'h00 && $changed(s.bitcnt) && s.rtsel >= 6'h06 && s.rtsel <= 6'h09
      && $stable(s.rtsel) |-> s.mode == MODE_VOICE;
  endproperty
  a_mono_sel: assert property (p_mono_sel) else $error("mono selection not voiceband");

  property p_stm_sel;
    s.dig && s.bitcnt == 7'h00 && $changed(s.bitcnt) && (s.rtsel == 6'h30 || s.rtsel == 6'h31)
      && $stable(s.rtsel) |-> s.mode == MODE_ST_MID;
  endproperty
  a_stm_sel: assert property (p_stm_sel) else $error("mid selection not decoded");

  sequence s_vb_sync_fall;
    s.dig && s.mode == MODE_VOICE && $fell(FRAME_SYNC_OUT);
  endsequence
  property p_vb_data_start;
    s_vb_sync_fall |-> DOUT_OE && s.bitcnt == 7'h01;
  endproperty
  a_vb_data_start: assert property (p_vb_data_start) else $error("voice data not after sync fall");

  property p_st_drive;
    s.dig && s.mode != MODE_VOICE && s.bitcnt != BIT_IDLE |-> DOUT_OE;
  endproperty
  a_st_drive: assert property (p_st_drive) else $error("stereo data not driven");

  // Read data only moves with an answer, so a slow master still sees it
  property p_rdata_hold;
    AVS_WAITREQUEST |-> $stable(AVS_READDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without an answer");

endmodule
`default_nettype wire

// ---- bench/pab_codec_model.sv ----
/*
  Behavioural model of the application codec on the PCM link.
  Assumes the bench resolves pin levels from the output enables.
*/
`timescale 1ns/10ps
`default_nettype none
module pab_codec_model (
  input wire logic bclk,
  input wire logic fs,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic [15:0] din_word,
  output logic din,
  output logic [15:0] voice_word,
  output logic [15:0] left_word,
  output int hi_len,
  output int idle_oe,
  output int period_ns
);
  int idx = 100;
  int run = 0;
  logic fs_q = 1'b0;
  logic [15:0] sh = 16'h0000;
  realtime t_rise = 0.0;

  // Known start values, so nothing reads as unknown
  initial begin
    din = 1'b0;
    voice_word = 16'h0000;
    left_word = 16'h0000;
    hi_len = 0;
    idle_oe = 0;
    period_ns = 0;
  end

  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  // sample on falling edge, count sync width
  always @(negedge bclk) begin
    if (fs && !fs_q) begin
      period_ns = int'($realtime - t_rise);
      t_rise = $realtime;
      run = 0;
    end
    if (fs) begin
      run = run + 1;
      idx = 0;
    end else begin
      if (fs_q) begin
        hi_len = run;
        left_word = sh; // Last word sent while sync was high
      end
      idx = idx + 1;
    end
    sh = {sh[14:0], dout};
    if (!fs && idx == 16) voice_word = sh;
    // only meaningful in voiceband, bench reads it there
    if (!fs && idx > 16 && idx < 65 && dout_oe) idle_oe = idle_oe + 1;
    fs_q = fs;
  end

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  // MSB first on rising edge; idle line toggles
  always @(posedge bclk) begin
    if (idx >= 0 && idx <= 15) din <= din_word[15 - idx];
    else din <= ~din; // Released line: no stale value to lean on
  end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
/*
  Testbench for the PCM audio bus master: registers over Avalon-MM,
  voiceband and stereo framing judged through the codec model.
  Assumes the design carries its own assertions.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pab_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, bclk_out, bclk_oe, fs_out, fs_oe, dout, dout_oe, din;
  logic [15:0] voice_word, left_word;
  int hi_len, idle_oe, period_ns;
  int failures = 0;
  int samples_checked = 0;
  logic [5:0] sel [13] = '{6'h06, 6'h07, 6'h09, 6'h0C, 6'h26, 6'h28, 6'h2E, 6'h30, 6'h31, 6'h0A, 6'h0B, 6'h27, 6'h2F};
  logic [1:0] md [13] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3};
  int per [4] = '{125000, 45390, 31250, 22857};

  pab_master dut (.CLOCK(clock), .NRST(nrst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .BCLK_OUT(bclk_out),
    .BCLK_OE(bclk_oe), .FRAME_SYNC_OUT(fs_out), .FRAME_SYNC_OE(fs_oe), .DOUT(dout),
    .DOUT_OE(dout_oe), .DIN(din));

  // Undriven clock and sync lines are pulled low at the connector
  pab_codec_model codec (.bclk(bclk_oe ? bclk_out : 1'b0), .fs(fs_oe ? fs_out : 1'b0),
    .dout(dout_oe ? dout : 1'bz), .dout_oe(dout_oe), .din_word(16'hD2E8), .din(din),
    .voice_word(voice_word), .left_word(left_word), .hi_len(hi_len), .idle_oe(idle_oe),
    .period_ns(period_ns));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Frame period may wander by a clock because the divider is fractional
  task automatic near(input int got, input int exp);
    samples_checked = samples_checked + 1;
    if (got < exp - 150 || got > exp + 150) begin
      failures = failures + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clock);
    // No cycle count assumed; only the watchdog ends a hang
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, 4'hF, q);
    check(q & m, exp);
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ------------------------------------------------------------
  always #50 clock = ~clock;

  // Whole run needs about 40000 cycles
  initial begin
    repeat (70000) @(posedge clock);
    failures = failures + 1;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    check({29'h0, bclk_oe, fs_oe, dout_oe}, 32'h0);
    rd(OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    rd(OFS_RTSEL, 32'h3F, 32'h7);
    rd(OFS_GAIN, 32'hFFFF, 32'h0343);
    wr(5'h1C, 32'hFFFFFFFF, 4'hF);
    rd(5'h1C, 32'hFFFFFFFF, 32'h0);
    wr(OFS_TXDATA, 32'h5A3CC3A5, 4'hF);
    wr(OFS_CTRL, 32'h3, 4'h1);
    rd(OFS_CTRL, 32'h3, 32'h3);
    repeat (3000) @(posedge clock);
    check({30'h0, bclk_oe, fs_oe}, 32'h3);
    check({16'h0, voice_word}, 32'h1D28);
    check(32'(hi_len), 32'h1);
    near(period_ns, 125000);
    check(32'(idle_oe), 32'h0);
    rd(OFS_RXDATA, 32'hFFFFFFFF, 32'hFFFFFA5D);
    rd(OFS_STATUS, 32'h7, 32'h4);
    wr(OFS_GAIN, 32'hFFFFFFFF, 4'h1);
    rd(OFS_GAIN, 32'hFFFF, 32'h03FF);
    wr(OFS_TXDATA, 32'h00001F01, 4'h3);
    repeat (2600) @(posedge clock);
    check({16'h0, voice_word}, 32'hF808);
    // Every mode class, checked for decode and rate; stereo classes also for word framing
    for (int i = 0; i < 13; i++) begin
      wr(OFS_RTSEL, {26'h0, sel[i]}, 4'h1);
      repeat (2600) @(posedge clock);
      rd(OFS_STATUS, 32'h3, {30'h0, md[i]});
      near(period_ns, per[md[i]]);
      if (md[i] != 2'h0) begin
        check(32'(hi_len), 32'h10);
        check({16'h0, left_word}, 32'h1F01);
      end
    end
    rd(OFS_RXDATA, 32'hFFFFFFFF, 32'hFFFFFA5D);
    wr(OFS_CTRL, 32'h0, 4'h1);
    repeat (3) @(posedge clock);
    check({29'h0, bclk_oe, fs_oe, dout_oe}, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
